//--- include/vbd_map.svh
// Encodings, field limits and level constants for the video back-end
`ifndef VBD_MAP_SVH
`define VBD_MAP_SVH
`define VBD_W_30 2'h0
`define VBD_W_20 2'h1
`define VBD_W_10 2'h2
`define VBD_TM_OFF 2'h0
`define VBD_TM_BARS 2'h1
`define VBD_TM_RAMP 2'h2
`define VBD_TM_LEVEL 2'h3
`define VBD_BAR_75 11'h5FF
`define VBD_DAC_MAX 11'h7FF
`define VBD_PROD_HI 20
`define VBD_PROD_LO 9
`define VBD_LSB8_MASK 10'h3FC
`define VBD_CGMS_LAST 5'h13
`define VBD_H_ONE 12'h001
`define VBD_V_ONE 11'h001
`define VBD_H_ZERO 12'h000
`define VBD_V_ZERO 11'h000
`define VBD_BAR_SHIFT 3
`endif

//--- include/vbd_pkg.sv
// Shared types of the video back-end datapath and timing block
package vbd_pkg;
    typedef struct packed {
        logic clip_en;
        logic [9:0] clip_lo;
        logic [9:0] clip_hi;
        logic [9:0] offset;
        logic [10:0] gain;
    } vbd_csm_cfg_t;
    typedef struct packed {
        logic [11:0] h_total, h_act_start, h_act_end;
        logic [11:0] hsync_w, pos_w, broad_w, eq_w, hs_out_start, hs_out_w;
        logic [10:0] v_total, v_act_start, v_act_end, v_broad_end, v_eq_end;
        logic [10:0] vs_out_start, vs_out_w, vbi_pass_first, vbi_pass_last;
        logic [10:0] cgms_line;
        logic hs_out_pol, vs_out_pol, trilevel_en;
    } vbd_tg_cfg_t;
    typedef struct packed {
        logic [10:0] blank, neg_sync, pos_sync, broad, eq, cgms_high;
    } vbd_lvl_cfg_t;
    typedef struct packed {
        logic [9:0] gy, bcb, rcr;
        logic source_hsync, source_vsync, source_field_id;
    } vbd_pix_t;
    typedef enum logic [1:0] {
        VBD_PH_CB = 2'b00,
        VBD_PH_Y0 = 2'b01,
        VBD_PH_CR = 2'b11,
        VBD_PH_Y1 = 2'b10
    } vbd_phase_t;
endpackage

//--- src/vbd_top.sv
// Video back-end: input buffer, formatter, scaling, timing, output selector
`timescale 1ns/1ps
`include "vbd_map.svh"
module vbd_top
    import vbd_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire vbd_pix_t pix_in,
    input wire logic pix_valid_in,
    output logic pix_ready_out,
    input wire logic emb_h_in,
    input wire logic emb_v_in,
    input wire logic emb_f_in,
    input wire logic [1:0] input_width_sel_in,
    input wire logic data8_mode_in,
    input wire logic embedded_timing_select_in,
    input wire logic master_slave_select_in,
    input wire logic pc_graphics_mode_in,
    input wire logic pixel_rate_high_in,
    input wire logic oversample_en_in,
    input wire logic sync_all_in,
    input wire logic vbi_pass_en_in,
    input wire logic digital_out_disable_in,
    input wire logic cgms_en_in,
    input wire logic [19:0] cgms_bits_in,
    input wire logic [11:0] cgms_start_in,
    input wire logic [7:0] cgms_bit_w_in,
    input wire logic [1:0] test_mode_in,
    input wire logic [2:0][10:0] test_level_in,
    input wire vbd_csm_cfg_t [2:0] csm_cfg_in,
    input wire vbd_tg_cfg_t tg_cfg_in,
    input wire vbd_lvl_cfg_t lvl_cfg_in,
    output logic [2:0][10:0] dac_out,
    output logic hsync_out,
    output logic vsync_out,
    output logic field_out,
    output logic source_hsync_out,
    output logic source_hsync_oe_out,
    output logic source_vsync_out,
    output logic source_vsync_oe_out,
    output logic [9:0] digital_data_out,
    output logic digital_out_en_out,
    output logic csc_bypass_out,
    output logic clk_full_en_out,
    output logic clk_half_en_out
);

    function automatic logic in_win(input logic [11:0] x, input logic [11:0] s,
                                    input logic [11:0] w);
        in_win = (x >= s) && ({1'b0, x} < ({1'b0, s} + {1'b0, w}));
    endfunction

    function automatic logic bar_on(input logic [2:0] idx, input int ch);
        // Channel 0 green, 1 blue, 2 red
        if (ch == 0)
            bar_on = ~idx[2];
        else if (ch == 1)
            bar_on = ~idx[0];
        else
            bar_on = ~idx[1];
    endfunction

    // Mode resolution
    wire w10 = (input_width_sel_in == `VBD_W_10);
    wire emb_eff = embedded_timing_select_in | w10;
    wire master_eff = master_slave_select_in & pc_graphics_mode_in
                      & ~emb_eff;

    // Clock driver strobes; clk_sys_in is the doubled clock
    logic full_r, half_r, full_nxt, half_nxt;
    assign full_nxt = ~full_r;
    assign half_nxt = full_r ? ~half_r : half_r;
    wire tick = oversample_en_in ? full_r : 1'b1;

    // Two-entry input buffer
    vbd_pix_t buf_r [2];
    logic wr_r, rd_r, rdy_r;
    logic [1:0] cnt_r;
    wire push = pix_valid_in & rdy_r;
    wire pop = tick & (cnt_r != 2'h0);
    wire [1:0] cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    wire vbd_pix_t ent = buf_r[rd_r];

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            cnt_r <= 2'h0;
            rdy_r <= 1'b0;
            full_r <= 1'b0;
            half_r <= 1'b0;
        end
        else if (ce_in)
        begin
            if (push)
            begin
                buf_r[wr_r] <= pix_in;
                wr_r <= ~wr_r;
            end
            if (pop)
                rd_r <= ~rd_r;
            cnt_r <= cnt_nxt;
            rdy_r <= cnt_nxt != 2'h2;
            full_r <= full_nxt;
            half_r <= half_nxt;
        end
    end

    // Timing counters, locked to the source when slave
    logic [11:0] hcnt_r, hcnt_nxt;
    logic [10:0] vcnt_r, vcnt_nxt;
    logic h_prev_r, v_prev_r, fid_r;
    wire src_h = emb_eff ? emb_h_in : ent.source_hsync;
    wire src_v = emb_eff ? emb_v_in : ent.source_vsync;
    wire src_f = emb_eff ? emb_f_in : ent.source_field_id;
    wire h_edge = pop & ~master_eff & src_h & ~h_prev_r;
    wire v_edge = pop & ~master_eff & src_v & ~v_prev_r;
    wire h_end = hcnt_r == (tg_cfg_in.h_total - `VBD_H_ONE);
    wire v_end = vcnt_r == (tg_cfg_in.v_total - `VBD_V_ONE);
    wire [10:0] vnext = v_end ? `VBD_V_ZERO : vcnt_r + `VBD_V_ONE;
    assign hcnt_nxt = (h_edge | h_end) ? `VBD_H_ZERO : hcnt_r + `VBD_H_ONE;
    assign vcnt_nxt = v_edge ? `VBD_V_ZERO :
                      (h_edge | h_end) ? vnext : vcnt_r;

    wire [11:0] vx = {1'b0, vcnt_r};
    wire act_line = in_win(vx, {1'b0, tg_cfg_in.v_act_start},
        {1'b0, tg_cfg_in.v_act_end - tg_cfg_in.v_act_start});
    wire vbi_line = vbi_pass_en_in & in_win(vx,
        {1'b0, tg_cfg_in.vbi_pass_first},
        {1'b0, tg_cfg_in.vbi_pass_last - tg_cfg_in.vbi_pass_first}
        + `VBD_H_ONE);
    wire act_pix = in_win(hcnt_r, tg_cfg_in.h_act_start,
        tg_cfg_in.h_act_end - tg_cfg_in.h_act_start);
    wire pass = act_pix & (act_line | vbi_line);
    wire broad_line = vcnt_r < tg_cfg_in.v_broad_end;
    wire eq_line = ~broad_line & (vcnt_r < tg_cfg_in.v_eq_end);
    wire [11:0] half_line = {1'b0, tg_cfg_in.h_total[11:1]};

    // Blanking level word per line type
    wire neg_win = in_win(hcnt_r, `VBD_H_ZERO, tg_cfg_in.hsync_w);
    wire pos_win = tg_cfg_in.trilevel_en
                   & in_win(hcnt_r, tg_cfg_in.hsync_w, tg_cfg_in.pos_w);
    wire broad_win = in_win(hcnt_r, `VBD_H_ZERO, tg_cfg_in.broad_w)
                   | in_win(hcnt_r, half_line, tg_cfg_in.broad_w);
    wire eq_win = in_win(hcnt_r, `VBD_H_ZERO, tg_cfg_in.eq_w)
                | in_win(hcnt_r, half_line, tg_cfg_in.eq_w);
    wire [10:0] sync_word =
        broad_line ? (broad_win ? lvl_cfg_in.broad : lvl_cfg_in.blank) :
        eq_line ? (eq_win ? lvl_cfg_in.eq : lvl_cfg_in.blank) :
        neg_win ? lvl_cfg_in.neg_sync :
        pos_win ? lvl_cfg_in.pos_sync : lvl_cfg_in.blank;

    // Display and source sync outputs
    wire hs_nxt = in_win(hcnt_r, tg_cfg_in.hs_out_start, tg_cfg_in.hs_out_w)
                  ^ tg_cfg_in.hs_out_pol;
    wire vs_nxt = in_win(vx, {1'b0, tg_cfg_in.vs_out_start},
                  {1'b0, tg_cfg_in.vs_out_w}) ^ tg_cfg_in.vs_out_pol;

    // Input formatter
    vbd_phase_t ph_r, ph_nxt;
    logic cr_sel_r;
    logic [2:0][9:0] ch_r;
    wire [9:0] mask = data8_mode_in ? `VBD_LSB8_MASK : 10'h3FF;
    wire [9:0] d_gy = ent.gy & mask;
    wire [9:0] d_cb = ent.bcb & mask;
    wire [9:0] d_cr = ent.rcr & mask;
    always_comb
    begin
        case (ph_r)
            VBD_PH_CB: ph_nxt = VBD_PH_Y0;
            VBD_PH_Y0: ph_nxt = VBD_PH_CR;
            VBD_PH_CR: ph_nxt = VBD_PH_Y1;
            default: ph_nxt = VBD_PH_CB;
        endcase
    end

    // Copy-control and colour-bar counters
    logic [7:0] cg_cnt_r;
    logic [4:0] cg_idx_r;
    logic cg_run_r;
    wire cg_line = cgms_en_in & (vcnt_r == tg_cfg_in.cgms_line);
    wire cg_start = cg_line & (hcnt_r == cgms_start_in);
    wire cg_step = cg_cnt_r == (cgms_bit_w_in - 8'h01);
    wire cg_bit = cgms_bits_in[`VBD_CGMS_LAST - cg_idx_r];
    logic [11:0] bar_cnt_r;
    logic [2:0] bar_idx_r;
    wire [11:0] bar_w = (tg_cfg_in.h_act_end - tg_cfg_in.h_act_start)
                        >> `VBD_BAR_SHIFT;
    wire bar_step = bar_cnt_r == (bar_w - `VBD_H_ONE);

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            hcnt_r <= `VBD_H_ZERO;
            vcnt_r <= `VBD_V_ZERO;
            h_prev_r <= 1'b0;
            v_prev_r <= 1'b0;
            fid_r <= 1'b0;
            ph_r <= VBD_PH_CB;
            cr_sel_r <= 1'b0;
            ch_r <= '0;
            cg_cnt_r <= 8'h00;
            cg_idx_r <= 5'h00;
            cg_run_r <= 1'b0;
            bar_cnt_r <= `VBD_H_ZERO;
            bar_idx_r <= 3'h0;
        end
        else if (ce_in && tick)
        begin
            hcnt_r <= hcnt_nxt;
            vcnt_r <= vcnt_nxt;
            if (cg_start)
            begin
                cg_run_r <= 1'b1;
                cg_cnt_r <= 8'h00;
                cg_idx_r <= 5'h00;
            end
            else if (cg_run_r)
            begin
                cg_cnt_r <= cg_step ? 8'h00 : cg_cnt_r + 8'h01;
                if (cg_step)
                begin
                    cg_idx_r <= cg_idx_r + 5'h01;
                    cg_run_r <= cg_idx_r != `VBD_CGMS_LAST;
                end
            end
            if (hcnt_r == tg_cfg_in.h_act_start)
            begin
                bar_cnt_r <= `VBD_H_ZERO;
                bar_idx_r <= 3'h0;
            end
            else
            begin
                bar_cnt_r <= bar_step ? `VBD_H_ZERO : bar_cnt_r + `VBD_H_ONE;
                bar_idx_r <= bar_idx_r + {2'h0, bar_step};
            end
            if (pop)
            begin
                h_prev_r <= src_h;
                v_prev_r <= src_v;
                fid_r <= src_f;
                cr_sel_r <= h_edge ? 1'b0 : ~cr_sel_r;
                ph_r <= h_edge ? VBD_PH_Y0 : ph_nxt;
                if (w10)
                begin
                    if (h_edge || ph_r == VBD_PH_CB)
                        ch_r[1] <= d_gy;
                    else if (ph_r == VBD_PH_CR)
                        ch_r[2] <= d_gy;
                    else
                        ch_r[0] <= d_gy;
                end
                else if (input_width_sel_in == `VBD_W_20)
                begin
                    ch_r[0] <= d_gy;
                    if (h_edge || !cr_sel_r)
                        ch_r[1] <= d_cb;
                    else
                        ch_r[2] <= d_cb;
                end
                else
                    ch_r <= {d_cr, d_cb, d_gy};
            end
        end
    end

    // Per-channel clip, offset, gain and output selection
    logic [2:0][10:0] word_nxt, prev_r;
    generate
        for (genvar c = 0; c < 3; c++)
        begin : g_ch
            wire [9:0] lo_cl = (ch_r[c] < csm_cfg_in[c].clip_lo) ?
                               csm_cfg_in[c].clip_lo : ch_r[c];
            wire [9:0] cl = (lo_cl > csm_cfg_in[c].clip_hi) ?
                            csm_cfg_in[c].clip_hi : lo_cl;
            wire [9:0] clipped = csm_cfg_in[c].clip_en ? cl : ch_r[c];
            wire [9:0] shifted = (clipped > csm_cfg_in[c].offset) ?
                clipped - csm_cfg_in[c].offset : 10'h000;
            wire [20:0] prod = shifted * csm_cfg_in[c].gain;
            wire [10:0] scaled = prod[`VBD_PROD_HI] ? `VBD_DAC_MAX :
                prod[`VBD_PROD_HI-1:`VBD_PROD_LO];
            wire [11:0] sum = {1'b0, scaled} + {1'b0, prev_r[c]};
            wire [10:0] vid = (oversample_en_in && !full_r) ?
                              sum[11:1] : scaled;
            wire [10:0] blank_w = (c == 0 || sync_all_in) ?
                                  sync_word : lvl_cfg_in.blank;
            wire [10:0] cg_w = (c == 0 && cg_bit) ?
                               lvl_cfg_in.cgms_high : lvl_cfg_in.blank;
            wire [10:0] bar_w11 = bar_on(bar_idx_r, c) ?
                                  `VBD_BAR_75 : 11'h000;
            wire [10:0] tst_w =
                (test_mode_in == `VBD_TM_BARS) ? bar_w11 :
                (test_mode_in == `VBD_TM_RAMP) ? hcnt_r[10:0] :
                test_level_in[c];
            wire tst_on = (test_mode_in != `VBD_TM_OFF) & act_pix & act_line;
            assign word_nxt[c] = tst_on ? tst_w :
                                 cg_run_r ? cg_w :
                                 pass ? vid : blank_w;

            always_ff @(posedge clk_sys_in)
            begin
                if (rst_in)
                    prev_r[c] <= 11'h000;
                else if (ce_in && tick)
                    prev_r[c] <= scaled;
            end
        end
    endgenerate

    // Registered outputs
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < 3; i++)
                dac_out[i] <= lvl_cfg_in.blank & 11'h000;
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
            field_out <= 1'b0;
            source_hsync_out <= 1'b0;
            source_hsync_oe_out <= 1'b0;
            source_vsync_out <= 1'b0;
            source_vsync_oe_out <= 1'b0;
            digital_data_out <= 10'h000;
            digital_out_en_out <= 1'b0;
            csc_bypass_out <= 1'b0;
            clk_full_en_out <= 1'b0;
            clk_half_en_out <= 1'b0;
            pix_ready_out <= 1'b0;
        end
        else if (ce_in)
        begin
            dac_out <= word_nxt;
            hsync_out <= hs_nxt;
            vsync_out <= vs_nxt;
            field_out <= fid_r;
            source_hsync_out <= hs_nxt;
            source_hsync_oe_out <= master_eff;
            source_vsync_out <= vs_nxt;
            source_vsync_oe_out <= master_eff;
            if (pop)
                digital_data_out <= ent.gy;
            digital_out_en_out <= w10 & ~digital_out_disable_in;
            csc_bypass_out <= pc_graphics_mode_in & pixel_rate_high_in;
            clk_full_en_out <= full_nxt;
            clk_half_en_out <= half_nxt & full_nxt;
            pix_ready_out <= cnt_nxt != 2'h2;
        end
    end

endmodule // vbd_top

//--- verification/vbd_properties.sv
// Port-level assertions for the video back-end top
`timescale 1ns/1ps
`include "vbd_map.svh"
module vbd_properties
    import vbd_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic pix_valid_in,
    input wire logic pix_ready_out,
    input wire logic [1:0] input_width_sel_in,
    input wire logic embedded_timing_select_in,
    input wire logic pc_graphics_mode_in,
    input wire logic pixel_rate_high_in,
    input wire logic digital_out_disable_in,
    input wire vbd_tg_cfg_t tg_cfg_in,
    input wire logic [2:0][10:0] dac_out,
    input wire logic hsync_out,
    input wire logic source_hsync_oe_out,
    input wire logic digital_out_en_out,
    input wire logic csc_bypass_out
);
    default clocking dc @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    logic [11:0] run_r;
    logic [11:0] run_nxt;
    logic [11:0] idle_r;
    logic [11:0] idle_nxt;
    wire hs_act = hsync_out ^ tg_cfg_in.hs_out_pol;
    // Length of the current hsync pulse and of the gap before it
    assign run_nxt = hs_act ? run_r + 12'h001 : 12'h000;
    assign idle_nxt = hs_act ? idle_r :
                      (run_r != 12'h000) ? 12'h001 : idle_r + 12'h001;
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            run_r <= 12'h000;
            idle_r <= 12'h000;
        end
        else if (ce_in)
        begin
            run_r <= run_nxt;
            idle_r <= idle_nxt;
        end
    end
    reset_clears_a: assert property ($fell(rst_in) |-> dac_out == '0
        && !digital_out_en_out) else $error("outputs not cleared by reset");
    fwd_width_a: assert property ((input_width_sel_in != `VBD_W_10) [*2]
        |-> !digital_out_en_out) else $error("forward bus on in wide mode");
    fwd_disable_a: assert property (digital_out_disable_in [*2]
        |-> !digital_out_en_out) else $error("forward bus not disabled");
    master_gate_a: assert property ((embedded_timing_select_in
        || !pc_graphics_mode_in) [*2] |-> !source_hsync_oe_out)
        else $error("master drive outside graphics");
    csc_bypass_a: assert property ((pc_graphics_mode_in
        && pixel_rate_high_in) [*2] |-> csc_bypass_out)
        else $error("converter not bypassed");
    ready_back_a: assert property (!pix_ready_out |-> ##[1:8] pix_ready_out)
        else $error("input buffer never drains");
    ready_cause_a: assert property ($fell(pix_ready_out)
        |-> $past(pix_valid_in) || $past(pix_valid_in, 2))
        else $error("buffer filled without words");
    // Only pulses after a full line gap; a resync may cut the others
    hs_width_a: assert property (!hs_act && run_r != 12'h000
        && idle_r == tg_cfg_in.h_total - tg_cfg_in.hs_out_w
        |-> run_r == tg_cfg_in.hs_out_w)
        else $error("display hsync width wrong");
    ce_freeze_a: assert property (!ce_in |=> $stable(dac_out)
        && $stable(hsync_out)) else $error("outputs moved with enable low");
endmodule // vbd_properties

bind vbd_top vbd_properties vbd_properties_inst (
    .clk_sys_in, .rst_in, .ce_in, .pix_valid_in, .pix_ready_out,
    .input_width_sel_in, .embedded_timing_select_in, .pc_graphics_mode_in,
    .pixel_rate_high_in, .digital_out_disable_in, .tg_cfg_in, .dac_out,
    .hsync_out, .source_hsync_oe_out, .digital_out_en_out, .csc_bypass_out
);

//--- verification/vbd_src_model.sv
// Video source model: streams raster words with dedicated syncs
`timescale 1ns/1ps
module vbd_src_model
    import vbd_pkg::*;
#(
    parameter int H = 64,
    parameter int V = 8
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic ready_in,
    input wire logic go_in,
    input wire logic [9:0] code_in,
    output vbd_pix_t pix_out,
    output logic valid_out
);
    int px;
    int ln;
    logic take;
    logic [9:0] code_r;
    logic [9:0] d;
    // Idle words carry the inverted code so a stale word never matches
    assign d = valid_out ? code_r : ~code_r;
    assign pix_out = '{d, d, d, valid_out && px < 4,
        valid_out && ln == 0, 1'b0};
    always @(posedge clk_in)
        take <= valid_out && ready_in && ce_in;
    always @(negedge clk_in)
    begin
        if (rst_in)
        begin
            px <= 0;
            ln <= 0;
            code_r <= code_in;
            valid_out <= 1'b0;
        end
        else if (take || !valid_out)
        begin
            // Word held until taken, then the raster steps on
            if (take)
                px <= (px == H - 1) ? 0 : px + 1;
            if (take && px == H - 1)
                ln <= (ln == V - 1) ? 0 : ln + 1;
            code_r <= code_in;
            valid_out <= go_in;
        end
    end
endmodule // vbd_src_model

//--- verification/tb.sv
// Self-checking bench for the video back-end top
`timescale 1ns/1ps
`include "vbd_map.svh"
module tb
    import vbd_pkg::*;
;
    logic clk_sys_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, go = 1'b1;
    logic pix_valid_in, pix_ready_out, data8_mode_in = 1'b0;
    logic embedded_timing_select_in = 1'b0, master_slave_select_in = 1'b1;
    logic pc_graphics_mode_in = 1'b1, pixel_rate_high_in = 1'b1;
    logic oversample_en_in = 1'b0, sync_all_in = 1'b0, cgms_en_in = 1'b0;
    logic vbi_pass_en_in = 1'b0, digital_out_disable_in = 1'b0;
    logic [1:0] input_width_sel_in = `VBD_W_30, test_mode_in = `VBD_TM_OFF;
    logic [19:0] cgms_bits_in = 20'hFFFFF;
    logic [11:0] cgms_start_in = 12'h014;
    logic [7:0] cgms_bit_w_in = 8'h01;
    logic [9:0] code = 10'h3FF;
    logic [2:0][10:0] test_level_in = {11'h333, 11'h222, 11'h111}, dac_out;
    vbd_pix_t pix_in;
    vbd_csm_cfg_t [2:0] csm_cfg_in;
    vbd_tg_cfg_t tg_cfg_in;
    vbd_lvl_cfg_t lvl_cfg_in = '{11'h100, 11'h010, 11'h040, 11'h020,
        11'h030, 11'h300};
    logic hsync_out, source_hsync_oe_out, digital_out_en_out, csc_bypass_out;
    logic vsync_out, emb_h = 1'b0;
    logic [9:0] digital_data_out;
    int bad_count = 0, tests_run = 0;

    vbd_top vbd_top_inst (
        .clk_sys_in, .rst_in, .ce_in, .pix_in, .pix_valid_in, .pix_ready_out,
        .emb_h_in(emb_h), .emb_v_in(1'b0), .emb_f_in(1'b0),
        .input_width_sel_in, .data8_mode_in, .embedded_timing_select_in,
        .master_slave_select_in, .pc_graphics_mode_in, .pixel_rate_high_in,
        .oversample_en_in, .sync_all_in, .vbi_pass_en_in,
        .digital_out_disable_in, .cgms_en_in, .cgms_bits_in, .cgms_start_in,
        .cgms_bit_w_in, .test_mode_in, .test_level_in, .csm_cfg_in,
        .tg_cfg_in, .lvl_cfg_in, .dac_out, .hsync_out, .vsync_out,
        .field_out(), .source_hsync_out(), .source_hsync_oe_out,
        .source_vsync_out(), .source_vsync_oe_out(), .digital_data_out,
        .digital_out_en_out, .csc_bypass_out, .clk_full_en_out(),
        .clk_half_en_out());
    vbd_src_model vbd_src_model_inst (.clk_in(clk_sys_in), .rst_in, .ce_in,
        .ready_in(pix_ready_out), .go_in(go), .code_in(code),
        .pix_out(pix_in), .valid_out(pix_valid_in));

    always #50 clk_sys_in = ~clk_sys_in;

    task chk(input bit ok, input string msg);
        tests_run++;
        if (!ok)
        begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task end_of_test;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    task bounded(input int n, input int lim, input string msg);
        chk(n < lim, msg);
        if (n >= lim)
            end_of_test;
    endtask

    task wait_dac(input int ch, input logic [10:0] v);
        int n;
        for (n = 0; n < 1100 && dac_out[ch] !== v; n++)
            tick(1);
        bounded(n, 1100, "converter word not seen");
    endtask

    task set_csm(input logic en, input logic [9:0] off, input logic [10:0] g);
        for (int i = 0; i < 3; i++)
            csm_cfg_in[i] = '{en, 10'h000, 10'h100, off, g};
    endtask

    task do_reset;
        rst_in = 1'b1;
        tick(20);
        chk(dac_out === '0 && pix_ready_out === 1'b0, "reset state");
        rst_in = 1'b0;
    endtask

    task check_modes;
        tick(3);
        chk(source_hsync_oe_out === 1'b1, "no master drive");
        chk(csc_bypass_out === 1'b1, "converter in path");
        chk(digital_out_en_out === 1'b0, "forward bus on");
        embedded_timing_select_in = 1'b1;
        input_width_sel_in = `VBD_W_10;
        tick(3);
        chk(source_hsync_oe_out === 1'b0, "master when embedded");
        chk(digital_out_en_out === 1'b1, "forward bus off");
        chk(digital_data_out === 10'h3FF, "forwarded word wrong");
        embedded_timing_select_in = 1'b0;
        tick(3);
        chk(source_hsync_oe_out === 1'b0, "master on narrow bus");
        pc_graphics_mode_in = 1'b0;
        master_slave_select_in = 1'b0;
        input_width_sel_in = `VBD_W_30;
        tick(3);
        chk(csc_bypass_out === 1'b0, "bypass in video mode");
    endtask

    task check_scale;
        set_csm(1'b1, 10'h000, 11'h400);
        wait_dac(0, 11'h200);
        set_csm(1'b0, 10'h000, 11'h400);
        wait_dac(0, 11'h7FE);
        set_csm(1'b0, 10'h2FF, 11'h7FF);
        wait_dac(0, 11'h3FF);
        data8_mode_in = 1'b1;
        set_csm(1'b0, 10'h000, 11'h400);
        wait_dac(0, 11'h7F8);
        data8_mode_in = 1'b0;
    endtask

    task check_insert;
        sync_all_in = 1'b1;
        wait_dac(0, 11'h010);
        chk(vsync_out === 1'b1, "display vsync off line 0");
        wait_dac(2, 11'h010);
        wait_dac(0, 11'h020);
        chk(vsync_out === 1'b0, "display vsync not on line 0");
        wait_dac(0, 11'h030);
        wait_dac(0, 11'h100);
        sync_all_in = 1'b0;
        test_mode_in = `VBD_TM_LEVEL;
        wait_dac(0, 11'h111);
        chk(dac_out[2:1] === {11'h333, 11'h222}, "test levels");
        test_mode_in = `VBD_TM_BARS;
        wait_dac(0, `VBD_BAR_75);
        test_mode_in = `VBD_TM_RAMP;
        wait_dac(0, 11'h025);
        embedded_timing_select_in = 1'b1;
        emb_h = 1'b1;
        tick(1);
        chk(dac_out[0] === 11'h026, "ramp not stepping");
        emb_h = 1'b0;
        tick(1);
        chk(dac_out[0] === 11'h010, "no lock to embedded hsync");
        embedded_timing_select_in = 1'b0;
        test_mode_in = `VBD_TM_OFF;
        cgms_en_in = 1'b1;
        wait_dac(0, 11'h300);
        cgms_en_in = 1'b0;
    endtask

    task check_buffer;
        int n;
        oversample_en_in = 1'b1;
        for (n = 0; n < 20 && pix_ready_out !== 1'b0; n++)
            tick(1);
        bounded(n, 20, "buffer never filled");
        ce_in = 1'b0;
        tick(3);
        ce_in = 1'b1;
        go = 1'b0;
        for (n = 0; n < 20 && pix_ready_out !== 1'b1; n++)
            tick(1);
        bounded(n, 20, "buffer never drained");
    endtask

    initial
    begin
        tg_cfg_in = '{12'h040, 12'h010, 12'h038, 12'h004, 12'h000, 12'h00C,
            12'h002, 12'h002, 12'h005, 11'h008, 11'h003, 11'h007, 11'h001,
            11'h002, 11'h000, 11'h001, 11'h000, 11'h000, 11'h002, 1'b1,
            1'b1, 1'b0};
        set_csm(1'b0, 10'h000, 11'h400);
        do_reset;
        check_modes;
        do_reset;
        check_scale;
        check_insert;
        check_buffer;
        end_of_test;
    end
endmodule // tb
